// File: bench/icu_issue.sv
// issue-side model: apb master that feeds operands and starts instructions
`timescale 1ns/1ns
module icu_issue (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
	end
	// one full transfer; released address and data show inverted values, not stale ones
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// File: bench/icu_top_checker.sv
// port-level assertions for the add-and-compare unit
`timescale 1ns/1ns
module icu_top_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire hit = paddr <= 8'h34 && paddr[1:0] == 2'h0;
	sequence rd_at(logic [7:0] ad);
		acc && !pwrite && paddr == ad;
	endsequence
	ready_always_a: assert property (pready)
		else $error("pready low");
	err_in_access_a: assert property (pslverr |-> acc)
		else $error("pslverr outside access");
	err_unmapped_a: assert property (acc && !hit |-> pslverr)
		else $error("unmapped access accepted");
	ok_mapped_a: assert property (acc && hit |-> !pslverr)
		else $error("mapped access refused");
	err_data_zero_a: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read carries data");
	// read data must not move between setups
	rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata changed outside setup");
	start_reads_zero_a: assert property (rd_at(icu_pkg::ADDR_CTRL) |-> !prdata[31])
		else $error("start bit read back");
	y_flag_only_a: assert property (rd_at(icu_pkg::ADDR_Y_LO) |-> prdata[31:1] == 31'h0)
		else $error("flag word has upper bits");
	y_high_zero_a: assert property (rd_at(icu_pkg::ADDR_Y_HI) |-> prdata == 32'h0)
		else $error("flag word high half nonzero");
endmodule
bind icu_top icu_top_checker u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr)
);

// File: bench/icu_top_tb.sv
// self-checking bench for the add-and-compare unit
`timescale 1ns/1ns
module icu_top_tb;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          err_total;
	int          n_compared;
	// negative 48-bit sum with a dropped carry; top 16 bits of X must not leak
	localparam logic [63:0] A1 = 64'h1234_8000_0000_0003;
	localparam logic [63:0] X1 = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] Z1 = 64'h0000_0000_0000_0005;
	localparam logic [63:0] A2 = 64'h1234_0000_0000_0010;
	localparam logic [63:0] X2 = 64'h0000_0000_0000_0020;
	localparam logic [63:0] Z2 = 64'h0000_0000_0000_0030;
	localparam logic [63:0] Z3 = 64'h1234_0000_0000_0030;
	localparam logic [63:0] A3 = 64'hFFFF_FFFF_5A80_0001;
	icu_top u_icu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	icu_issue u_iss (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	always #5 pclk = ~pclk;
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [63:0] exp_c(input logic [7:0] m, input logic [63:0] a, x);
		logic [47:0] s48;
		logic [23:0] s24;
		s48 = a[47:0] + x[47:0];
		s24 = a[23:0] + x[23:0];
		return m[0] ? {32'h0, a[31:24], s24} : {a[63:48], s48};
	endfunction
	// signedness sense flips between the two widths
	function automatic logic exp_y(input logic [2:0] op, input logic [7:0] m,
		input logic [63:0] c, z);
		int                 w;
		logic               sg;
		logic [63:0]        mk;
		logic signed [65:0] l;
		logic signed [65:0] r;
		w = m[0] ? 24 : (m[3] ? 64 : 48);
		sg = m[0] ? m[4] : !m[4];
		mk = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
		l = {2'b0, c & mk};
		r = {2'b0, z & mk};
		if (sg && c[w-1])
			l = l - (66'sd1 <<< w);
		if (sg && z[w-1])
			r = r - (66'sd1 <<< w);
		case (op)
			3'd0: return l == r;
			3'd1: return l != r;
			3'd2: return l >= r;
			3'd3: return l < r;
			3'd4: return l <= r;
			default: return l > r;
		endcase
	endfunction
	task automatic wr2(input logic [7:0] ad, input logic [63:0] v);
		logic [31:0] q;
		logic        e;
		u_iss.xfer(1'b1, ad, v[31:0], q, e);
		u_iss.xfer(1'b1, ad + 8'h4, v[63:32], q, e);
	endtask
	task automatic rd2(input logic [7:0] ad, output logic [63:0] v);
		logic [31:0] lo;
		logic [31:0] hi;
		logic        e;
		u_iss.xfer(1'b0, ad, 32'h0, lo, e);
		u_iss.xfer(1'b0, ad + 8'h4, 32'h0, hi, e);
		v = {hi, lo};
	endtask
	task automatic run_op(input logic [2:0] op, input logic [7:0] m, input logic [63:0] a, x, z);
		logic [31:0] s;
		logic        e;
		logic [63:0] g;
		int          n;
		wr2(icu_pkg::ADDR_A_LO, a);
		wr2(icu_pkg::ADDR_X_LO, x);
		wr2(icu_pkg::ADDR_Z_LO, z);
		wr2(icu_pkg::ADDR_B_LO, 64'h0);
		u_iss.xfer(1'b1, icu_pkg::ADDR_CTRL, {1'b1, 15'h0, m, 5'h0, op}, s, e);
		s = 32'h0;
		n = 0;
		while (s[icu_pkg::STAT_DONE] !== 1'b1 && n < 10)
		begin
			u_iss.xfer(1'b0, icu_pkg::ADDR_STATUS, 32'h0, s, e);
			n++;
		end
		check(64'(s), 64'h2);
		rd2(icu_pkg::ADDR_C_LO, g);
		check(g, exp_c(m, a, x));
		rd2(icu_pkg::ADDR_Y_LO, g);
		check(g, {63'h0, exp_y(op, m, exp_c(m, a, x), z)});
		u_iss.xfer(1'b1, icu_pkg::ADDR_STATUS, 32'h2, s, e);
	endtask
	task automatic t_regs;
		logic [31:0] q;
		logic        e;
		u_iss.xfer(1'b0, icu_pkg::ADDR_STATUS, 32'h0, q, e);
		check(64'(q), 64'h0);
		u_iss.xfer(1'b1, icu_pkg::ADDR_C_LO, 32'hFFFF_FFFF, q, e);
		u_iss.xfer(1'b0, icu_pkg::ADDR_C_LO, 32'h0, q, e);
		check(64'(q), 64'h0);
		u_iss.xfer(1'b0, 8'h38, 32'h0, q, e);
		check({q, 31'h0, e}, 64'h1);
		u_iss.xfer(1'b0, icu_pkg::ADDR_CTRL, 32'h0, q, e);
		check(64'(q), 64'h0);
		$display("t_regs done");
	endtask
	task automatic t_cmp64;
		for (int k = 0; k < 12; k++)
			run_op(3'(k % 6), (k < 6) ? 8'h00 : 8'h10, A1, X1, Z1);
		$display("t_cmp64 done");
	endtask
	task automatic t_full64;
		run_op(3'd0, 8'h00, A2, X2, Z2);
		run_op(3'd0, 8'h08, A2, X2, Z2);
		run_op(3'd1, 8'h08, A2, X2, Z2);
		run_op(3'd0, 8'h18, A2, X2, Z3);
		$display("t_full64 done");
	endtask
	task automatic t_half32;
		for (int k = 0; k < 12; k++)
			run_op(3'(k % 6), (k < 6) ? 8'h01 : 8'h11, A3, 64'h1, Z1);
		$display("t_half32 done");
	endtask
	task automatic t_refuse;
		logic [31:0] w [3] = '{32'h8000_0200, 32'h8000_0400, 32'h8000_0006};
		logic [31:0] s;
		logic        e;
		foreach (w[i])
		begin
			u_iss.xfer(1'b1, icu_pkg::ADDR_CTRL, w[i], s, e);
			u_iss.xfer(1'b0, icu_pkg::ADDR_STATUS, 32'h0, s, e);
			check(64'(s), 64'h4);
			u_iss.xfer(1'b1, icu_pkg::ADDR_STATUS, 32'h4, s, e);
		end
		$display("t_refuse done");
	endtask
	initial
	begin
		#200000;
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		err_total = 0;
		n_compared = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_cmp64();
		t_full64();
		t_half32();
		t_refuse();
		tally_and_finish();
	end
endmodule

// File: src/icu_cmp.sv
// equal and less-than of two extended operands, signed or unsigned
`timescale 1ns/1ns
module icu_cmp #(
	parameter int W = 64
) (
	input  wire logic [W-1:0] lhs,
	input  wire logic [W-1:0] rhs,
	input  wire logic         is_signed,
	output logic              eq,
	output logic              lt
);
	logic lt_s;
	logic lt_u;

	assign lt_s = $signed(lhs) < $signed(rhs);
	assign lt_u = lhs < rhs;
	assign eq   = lhs == rhs;
	assign lt   = is_signed ? lt_s : lt_u;
endmodule

// File: src/icu_pkg.sv
// constants and types shared by the integer add-and-compare unit
package icu_pkg;

	// apb byte offsets, one aligned 32-bit word each; 64-bit registers take a lo and a hi word
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_A_LO   = 8'h08;
	localparam logic [7:0] ADDR_A_HI   = 8'h0C;
	localparam logic [7:0] ADDR_X_LO   = 8'h10;
	localparam logic [7:0] ADDR_X_HI   = 8'h14;
	localparam logic [7:0] ADDR_Z_LO   = 8'h18;
	localparam logic [7:0] ADDR_Z_HI   = 8'h1C;
	localparam logic [7:0] ADDR_B_LO   = 8'h20;
	localparam logic [7:0] ADDR_B_HI   = 8'h24;
	localparam logic [7:0] ADDR_C_LO   = 8'h28;
	localparam logic [7:0] ADDR_C_HI   = 8'h2C;
	localparam logic [7:0] ADDR_Y_LO   = 8'h30;
	localparam logic [7:0] ADDR_Y_HI   = 8'h34;

	// control word fields
	localparam int CTRL_OP_LSB  = 0;
	localparam int CTRL_OP_W    = 3;
	localparam int CTRL_MOD_LSB = 8;
	localparam int CTRL_MOD_W   = 8;
	localparam int CTRL_START   = 31;

	// status word fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_BAD  = 2;

	// modifier_field bit positions
	localparam int MOD_HALF = 0;
	localparam int MOD_SEL1 = 1;
	localparam int MOD_SEL2 = 2;
	localparam int MOD_FULL = 3;
	localparam int MOD_UNS  = 4;
	localparam int MOD_RSV5 = 5;
	localparam int MOD_RSV7 = 7;

	// operand geometry
	localparam int WORD_W    = 64;
	localparam int HALF_W    = 32;
	localparam int WIDE_SUM  = 48;
	localparam int WIDE_HEAD = 16;
	localparam int HALF_SUM  = 24;
	localparam int HALF_HEAD = 8;

	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [63:0] FLAG_TRUE = 64'h0000_0000_0000_0001;
	localparam logic [63:0] FLAG_FALSE = 64'h0000_0000_0000_0000;

	typedef enum logic [2:0] {
		op_equal,
		op_not_equal,
		op_greater_equal,
		op_less_than,
		op_less_equal,
		op_greater
	} icu_op_t;

endpackage

// File: src/icu_sum.sv
// forms the new C word from A and X for either operand width
`timescale 1ns/1ns
module icu_sum (
	input  wire logic [63:0] a_word,
	input  wire logic [63:0] x_word,
	input  wire logic        half,
	output logic      [63:0] c_word
);
	logic [icu_pkg::WIDE_SUM-1:0] sum_wide;
	logic [icu_pkg::HALF_SUM-1:0] sum_half;

	// carries out of the top of each field are dropped
	assign sum_wide = a_word[icu_pkg::WIDE_SUM-1:0] + x_word[icu_pkg::WIDE_SUM-1:0];
	assign sum_half = a_word[icu_pkg::HALF_SUM-1:0] + x_word[icu_pkg::HALF_SUM-1:0];

	assign c_word = half
		? {icu_pkg::WORD_ZERO, a_word[icu_pkg::HALF_W-1:icu_pkg::HALF_SUM], sum_half}
		: {a_word[icu_pkg::WORD_W-1:icu_pkg::WIDE_SUM], sum_wide};
endmodule

// File: src/icu_top.sv
// integer add-and-compare unit with apb register access
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
module icu_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ_Z,
		ST_WRITE_C,
		ST_WRITE_Y
	} icu_state_t;

	icu_state_t state_q;
	icu_state_t state_d;

	// halves of a 64-bit register as seen over the 32-bit bus
	localparam int LO_TOP = icu_pkg::HALF_W - 1;
	localparam int HI_BOT = icu_pkg::HALF_W;
	localparam int HI_TOP = icu_pkg::WORD_W - 1;

	logic [63:0] a_q;
	logic [63:0] x_q;
	logic [63:0] z_q;
	logic [63:0] b_q;
	logic [63:0] c_q;
	logic [63:0] y_q;
	logic [63:0] z_seen_q;
	logic [2:0]  op_q;
	logic [7:0]  mod_q;
	logic        done_q;
	logic        bad_q;

	// apb decode
	logic        wr_en;
	logic        rd_hit;
	logic        busy;
	logic        hit_ctrl;
	logic        hit_status;
	logic        hit_a_lo;
	logic        hit_a_hi;
	logic        hit_x_lo;
	logic        hit_x_hi;
	logic        hit_z_lo;
	logic        hit_z_hi;
	logic        hit_b_lo;
	logic        hit_b_hi;
	logic        hit_c_lo;
	logic        hit_c_hi;
	logic        hit_y_lo;
	logic        hit_y_hi;
	logic        hit_any;
	logic        start;
	logic        op_ok;
	logic        variant_ok;
	logic        launch;
	logic        reject;
	logic [31:0] status_word;
	logic [31:0] ctrl_word;

	assign busy       = state_q != ST_IDLE;
	assign hit_ctrl   = paddr == icu_pkg::ADDR_CTRL;
	assign hit_status = paddr == icu_pkg::ADDR_STATUS;
	assign hit_a_lo   = paddr == icu_pkg::ADDR_A_LO;
	assign hit_a_hi   = paddr == icu_pkg::ADDR_A_HI;
	assign hit_x_lo   = paddr == icu_pkg::ADDR_X_LO;
	assign hit_x_hi   = paddr == icu_pkg::ADDR_X_HI;
	assign hit_z_lo   = paddr == icu_pkg::ADDR_Z_LO;
	assign hit_z_hi   = paddr == icu_pkg::ADDR_Z_HI;
	assign hit_b_lo   = paddr == icu_pkg::ADDR_B_LO;
	assign hit_b_hi   = paddr == icu_pkg::ADDR_B_HI;
	assign hit_c_lo   = paddr == icu_pkg::ADDR_C_LO;
	assign hit_c_hi   = paddr == icu_pkg::ADDR_C_HI;
	assign hit_y_lo   = paddr == icu_pkg::ADDR_Y_LO;
	assign hit_y_hi   = paddr == icu_pkg::ADDR_Y_HI;
	assign hit_any    = hit_ctrl | hit_status | hit_a_lo | hit_a_hi | hit_x_lo | hit_x_hi
		| hit_z_lo | hit_z_hi | hit_b_lo | hit_b_hi | hit_c_lo | hit_c_hi
		| hit_y_lo | hit_y_hi;

	// zero-wait slave: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit_any;
	assign wr_en   = psel & penable & pwrite & hit_any;
	assign rd_hit  = psel & ~pwrite & hit_any;

	// a start write launches only when the modifier names the integer variant
	assign start      = wr_en & hit_ctrl & pwdata[icu_pkg::CTRL_START] & ~busy;
	assign op_ok      = pwdata[icu_pkg::CTRL_OP_LSB +: icu_pkg::CTRL_OP_W] <= 3'(icu_pkg::op_greater);
	assign variant_ok = ~pwdata[icu_pkg::CTRL_MOD_LSB + icu_pkg::MOD_SEL1]
		& ~pwdata[icu_pkg::CTRL_MOD_LSB + icu_pkg::MOD_SEL2];
	assign launch     = start & op_ok & variant_ok;
	assign reject     = start & ~(op_ok & variant_ok);

	assign ctrl_word = {16'h0000, mod_q, 5'h00, op_q};
	assign status_word = {29'h0000_0000, bad_q, done_q, busy};

	// operand and control registers; writes while busy are dropped so the
	// operands cannot change under a running instruction
	logic wr_ok;

	assign wr_ok = wr_en & ~busy;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			a_q <= 64'h0000_0000_0000_0000;
		else if (wr_ok && hit_a_lo)
			a_q[LO_TOP:0] <= pwdata;
		else if (wr_ok && hit_a_hi)
			a_q[HI_TOP:HI_BOT] <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			x_q <= 64'h0000_0000_0000_0000;
		else if (wr_ok && hit_x_lo)
			x_q[LO_TOP:0] <= pwdata;
		else if (wr_ok && hit_x_hi)
			x_q[HI_TOP:HI_BOT] <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			z_q <= 64'h0000_0000_0000_0000;
		else if (wr_ok && hit_z_lo)
			z_q[LO_TOP:0] <= pwdata;
		else if (wr_ok && hit_z_hi)
			z_q[HI_TOP:HI_BOT] <= pwdata;
	end

	// b is kept only so software can read back what it supplied
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			b_q <= 64'h0000_0000_0000_0000;
		else if (wr_ok && hit_b_lo)
			b_q[LO_TOP:0] <= pwdata;
		else if (wr_ok && hit_b_hi)
			b_q[HI_TOP:HI_BOT] <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_q  <= 3'h0;
			mod_q <= 8'h00;
		end
		else if (wr_ok && hit_ctrl)
		begin
			op_q  <= pwdata[icu_pkg::CTRL_OP_LSB +: icu_pkg::CTRL_OP_W];
			mod_q <= pwdata[icu_pkg::CTRL_MOD_LSB +: icu_pkg::CTRL_MOD_W];
		end
	end

	// datapath
	logic        half;
	logic        full_cmp;
	logic        sign_cmp;
	logic [63:0] c_next;
	logic [63:0] lhs;
	logic [63:0] rhs;
	logic [63:0] lhs_wide;
	logic [63:0] rhs_wide;
	logic [63:0] lhs_half;
	logic [63:0] rhs_half;
	logic        cmp_eq;
	logic        cmp_lt;
	logic        cond;

	assign half     = mod_q[icu_pkg::MOD_HALF];
	assign full_cmp = mod_q[icu_pkg::MOD_FULL] & ~half;
	// the sign sense of bit 4 flips between the two widths
	assign sign_cmp = half ? mod_q[icu_pkg::MOD_UNS] : ~mod_q[icu_pkg::MOD_UNS];

	icu_sum u_sum (
		.a_word (a_q),
		.x_word (x_q),
		.half   (half),
		.c_word (c_next)
	);

	// compare against what C now holds and the Z captured before the C write
	assign lhs_wide = sign_cmp
		? {{icu_pkg::WIDE_HEAD{c_q[icu_pkg::WIDE_SUM-1]}}, c_q[icu_pkg::WIDE_SUM-1:0]}
		: {{icu_pkg::WIDE_HEAD{1'b0}}, c_q[icu_pkg::WIDE_SUM-1:0]};
	assign rhs_wide = sign_cmp
		? {{icu_pkg::WIDE_HEAD{z_seen_q[icu_pkg::WIDE_SUM-1]}}, z_seen_q[icu_pkg::WIDE_SUM-1:0]}
		: {{icu_pkg::WIDE_HEAD{1'b0}}, z_seen_q[icu_pkg::WIDE_SUM-1:0]};
	assign lhs_half = sign_cmp
		? {{(icu_pkg::WORD_W - icu_pkg::HALF_SUM){c_q[icu_pkg::HALF_SUM-1]}},
			c_q[icu_pkg::HALF_SUM-1:0]}
		: {{(icu_pkg::WORD_W - icu_pkg::HALF_SUM){1'b0}}, c_q[icu_pkg::HALF_SUM-1:0]};
	assign rhs_half = sign_cmp
		? {{(icu_pkg::WORD_W - icu_pkg::HALF_SUM){z_seen_q[icu_pkg::HALF_SUM-1]}},
			z_seen_q[icu_pkg::HALF_SUM-1:0]}
		: {{(icu_pkg::WORD_W - icu_pkg::HALF_SUM){1'b0}},
			z_seen_q[icu_pkg::HALF_SUM-1:0]};
	// full compare only means something for equal and not equal
	assign lhs = half ? lhs_half : (full_cmp ? c_q : lhs_wide);
	assign rhs = half ? rhs_half : (full_cmp ? z_seen_q : rhs_wide);

	icu_cmp #(
		.W (icu_pkg::WORD_W)
	) u_cmp (
		.lhs       (lhs),
		.rhs       (rhs),
		.is_signed (sign_cmp),
		.eq        (cmp_eq),
		.lt        (cmp_lt)
	);

	always_comb
	begin
		unique case (op_q)
			3'(icu_pkg::op_equal):         cond = cmp_eq;
			3'(icu_pkg::op_not_equal):     cond = ~cmp_eq;
			3'(icu_pkg::op_greater_equal): cond = ~cmp_lt;
			3'(icu_pkg::op_less_than):     cond = cmp_lt;
			3'(icu_pkg::op_less_equal):    cond = cmp_lt | cmp_eq;
			3'(icu_pkg::op_greater):       cond = ~(cmp_lt | cmp_eq);
			default:                       cond = 1'b0;
		endcase
	end

	// sequencer
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:
				if (launch)
					state_d = ST_READ_Z;
			ST_READ_Z:
				state_d = ST_WRITE_C;
			ST_WRITE_C:
				state_d = ST_WRITE_Y;
			ST_WRITE_Y:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// result registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			z_seen_q <= 64'h0000_0000_0000_0000;
			c_q      <= 64'h0000_0000_0000_0000;
			y_q      <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			if (state_q == ST_READ_Z)
				z_seen_q <= z_q;
			if (state_q == ST_WRITE_C)
				c_q <= c_next;
			if (state_q == ST_WRITE_Y)
				y_q <= cond ? icu_pkg::FLAG_TRUE : icu_pkg::FLAG_FALSE;
		end
	end

	// sticky flags, cleared by writing one; a new event beats the clear
	logic clr_done;
	logic clr_bad;
	logic set_done;

	assign clr_done = wr_en & hit_status & pwdata[icu_pkg::STAT_DONE];
	assign clr_bad  = wr_en & hit_status & pwdata[icu_pkg::STAT_BAD];
	assign set_done = state_q == ST_WRITE_Y;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_q <= 1'b0;
			bad_q  <= 1'b0;
		end
		else
		begin
			done_q <= set_done | (done_q & ~clr_done);
			bad_q  <= reject | (bad_q & ~clr_bad);
		end
	end

	// read mux; 32-bit mode results sit in the low word, high word zero
	logic [31:0] rd_word;

	assign rd_word =
		hit_ctrl   ? ctrl_word :
		hit_status ? status_word :
		hit_a_lo   ? a_q[LO_TOP:0] :
		hit_a_hi   ? a_q[HI_TOP:HI_BOT] :
		hit_x_lo   ? x_q[LO_TOP:0] :
		hit_x_hi   ? x_q[HI_TOP:HI_BOT] :
		hit_z_lo   ? z_q[LO_TOP:0] :
		hit_z_hi   ? z_q[HI_TOP:HI_BOT] :
		hit_b_lo   ? b_q[LO_TOP:0] :
		hit_b_hi   ? b_q[HI_TOP:HI_BOT] :
		hit_c_lo   ? c_q[LO_TOP:0] :
		hit_c_hi   ? c_q[HI_TOP:HI_BOT] :
		hit_y_lo   ? y_q[LO_TOP:0] :
		hit_y_hi   ? y_q[HI_TOP:HI_BOT] :
		icu_pkg::WORD_ZERO;

	// read data registered in setup so it is steady through the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= icu_pkg::WORD_ZERO;
		else if (rd_hit && !penable)
			prdata <= rd_word;
		else if (psel && !penable)
			prdata <= icu_pkg::WORD_ZERO;
	end

endmodule
